// ### ofd_pkg.sv
package ofd_pkg;

  // operand sizes and field codes
  localparam int unsigned WORD_W        = 16;
  localparam logic [1:0]  MOD_NO_DISP   = 2'h0;
  localparam logic [1:0]  MOD_DISP8     = 2'h1;
  localparam logic [1:0]  MOD_DISP16    = 2'h2;
  localparam logic [1:0]  MOD_REGISTER  = 2'h3;
  localparam logic [2:0]  MEM_DIRECT    = 3'h6;
  localparam logic [15:0] WORD_RST      = 16'h0000;
  localparam logic [7:0]  BYTE_RST      = 8'h00;
  localparam logic [31:0] IMM_RST       = 32'h00000000;
  localparam logic [2:0]  LEN_NONE      = 3'h0;
  localparam logic [2:0]  LEN_ONE       = 3'h1;
  localparam logic [2:0]  LEN_TWO       = 3'h2;
  localparam logic [2:0]  LEN_FAR       = 3'h4;

  typedef logic [WORD_W-1:0] ofd_word_t;

  // {W, field} gives the register directly
  typedef enum logic [3:0] {
    GPR_ACCUMULATOR_LOW   = 4'b0000, GPR_COUNT_LOW          = 4'b0001,
    GPR_DATA_LOW          = 4'b0010, GPR_BASE_LOW           = 4'b0011,
    GPR_ACCUMULATOR_HIGH  = 4'b0100, GPR_COUNT_HIGH         = 4'b0101,
    GPR_DATA_HIGH         = 4'b0110, GPR_BASE_HIGH          = 4'b0111,
    GPR_ACCUMULATOR_WORD  = 4'b1000, GPR_COUNT_WORD         = 4'b1001,
    GPR_DATA_WORD_REG     = 4'b1010, GPR_BASE_WORD_REG      = 4'b1011,
    GPR_STACK_POINTER     = 4'b1100, GPR_FRAME_BASE_POINTER = 4'b1101,
    GPR_SOURCE_INDEX      = 4'b1110, GPR_DEST_INDEX         = 4'b1111
  } ofd_gpr_e;

  typedef enum logic [1:0] {
    SEG_DATA_ONE = 2'b00, SEG_PROGRAM = 2'b01, SEG_STACK = 2'b10, SEG_DATA_ZERO = 2'b11
  } ofd_seg_e;

  typedef enum logic [3:0] {
    FORM_MODRM = 4'b0000, FORM_MODRM_IMM = 4'b0001, FORM_ACC_IMM = 4'b0010,
    FORM_SHORT = 4'b0011, FORM_NEAR      = 4'b0100, FORM_FAR     = 4'b0101,
    FORM_RETN  = 4'b0110, FORM_XLAT      = 4'b0111, FORM_BLOCK   = 4'b1000
  } ofd_form_e;

  typedef enum logic [2:0] {
    FLAG_KEEP = 3'b000, FLAG_CLEAR = 3'b001, FLAG_SET = 3'b010,
    FLAG_RESULT = 3'b011, FLAG_UNDEF = 3'b100, FLAG_RESTORE = 3'b101
  } ofd_flag_e;

  typedef struct packed {
    ofd_form_e  form;
    logic       w;
    logic       s;
    logic [1:0] sreg;
    logic       ovr_en;
    ofd_seg_e   ovr;
  } ofd_desc_s;

  typedef struct packed {
    ofd_word_t  base_word;
    ofd_word_t  frame_base;
    ofd_word_t  src_index;
    ofd_word_t  dst_index;
    logic [7:0] acc_low;
    ofd_word_t  pc_end;
  } ofd_regs_s;

  typedef struct packed {
    ofd_form_e form;
    logic      word;
    logic      mem_op;
    ofd_gpr_e  reg_dst;
    ofd_gpr_e  reg_src;
    ofd_word_t ea;
    ofd_word_t ea_dst;
    ofd_seg_e  data_seg;
    ofd_seg_e  dst_seg;
    ofd_seg_e  sreg_sel;
    ofd_word_t imm;
    ofd_word_t target_pc;
    ofd_word_t target_ps;
  } ofd_res_s;

  function automatic ofd_gpr_e gpr_sel(input logic w, input logic [2:0] f);
    return ofd_gpr_e'({w, f});
  endfunction

  function automatic ofd_word_t sext8(input logic [7:0] b);
    return {{8{b[7]}}, b};
  endfunction

  function automatic logic [2:0] disp_len(input logic [1:0] md, input logic [2:0] m);
    if (md == MOD_DISP8) return LEN_ONE;
    if (md == MOD_DISP16 || (md == MOD_NO_DISP && m == MEM_DIRECT)) return LEN_TWO;
    return LEN_NONE;
  endfunction

  function automatic logic [2:0] imm_len(input ofd_desc_s d);
    case (d.form)
      FORM_MODRM_IMM, FORM_ACC_IMM: return (!d.w || d.s) ? LEN_ONE : LEN_TWO;
      FORM_SHORT:                   return LEN_ONE;
      FORM_NEAR, FORM_RETN:         return LEN_TWO;
      FORM_FAR:                     return LEN_FAR;
      default:                      return LEN_NONE;
    endcase
  endfunction

endpackage

// ### ofd_decoder.sv
`timescale 1ns/100ps
module ofd_decoder (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // instruction start
  input  wire logic               start,
  input  wire ofd_pkg::ofd_desc_s start_desc,
  // operand bytes from fetch
  input  wire logic               byte_valid,
  input  wire logic [7:0]         byte_data,
  // register values seen at completion
  input  wire ofd_pkg::ofd_regs_s regs_in,
  // flag update
  input  wire ofd_pkg::ofd_flag_e flag_act,
  input  wire logic               flag_old,
  input  wire logic               flag_res,
  input  wire logic               flag_saved,
  // status and results
  output logic                    idle_q,
  output logic                    want_byte_q,
  output logic                    done_q,
  output ofd_pkg::ofd_res_s       res_q,
  output logic                    flag_new_q
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_MODRM = 3'b001, ST_DISP = 3'b010, ST_IMM = 3'b011, ST_FINISH = 3'b100
  } ofd_state_e;

  ofd_state_e         state_q,   state_d;
  ofd_pkg::ofd_desc_s desc_q,    desc_d;
  logic [7:0]         modrm_q,   modrm_d;
  logic [15:0]        disp_q,    disp_d;
  logic [2:0]         disp_n_q,  disp_n_d;
  logic [31:0]        imm_q,     imm_d;
  logic [2:0]         imm_n_q,   imm_n_d;
  logic [1:0]         cnt_q,     cnt_d;
  logic               done_d;
  logic               flag_new_d;
  ofd_pkg::ofd_res_s  res_d;
  logic               take;
  logic [1:0]         md;
  logic [2:0]         mf;
  logic [2:0]         next_len;
  ofd_pkg::ofd_word_t base;
  ofd_pkg::ofd_word_t disp16;

  assign take = want_byte_q & byte_valid;
  assign md   = modrm_q[7:6];
  assign mf   = modrm_q[2:0];

  // effective address base per memory field and mode
  always_comb begin
    case (mf)
      3'b000:  base = regs_in.base_word + regs_in.src_index;
      3'b001:  base = regs_in.base_word + regs_in.dst_index;
      3'b010:  base = regs_in.frame_base + regs_in.src_index;
      3'b011:  base = regs_in.frame_base + regs_in.dst_index;
      3'b100:  base = regs_in.src_index;
      3'b101:  base = regs_in.dst_index;
      3'b110:  base = (md == ofd_pkg::MOD_NO_DISP) ? ofd_pkg::WORD_RST : regs_in.frame_base;
      default: base = regs_in.base_word;
    endcase
    // one byte is always signed; two bytes were stored low then high
    disp16 = (disp_n_q == ofd_pkg::LEN_ONE) ? ofd_pkg::sext8(disp_q[7:0]) : disp_q;
  end

  // sequencing over operand bytes
  always_comb begin
    state_d  = state_q;
    desc_d   = desc_q;
    modrm_d  = modrm_q;
    disp_d   = disp_q;
    disp_n_d = disp_n_q;
    imm_d    = imm_q;
    imm_n_d  = imm_n_q;
    cnt_d    = cnt_q;
    done_d   = 1'b0;
    res_d    = res_q;
    next_len = ofd_pkg::LEN_NONE;
    case (state_q)
      ST_IDLE: begin
        if (start) begin
          desc_d   = start_desc;
          disp_d   = ofd_pkg::WORD_RST;
          disp_n_d = ofd_pkg::LEN_NONE;
          imm_d    = ofd_pkg::IMM_RST;
          imm_n_d  = ofd_pkg::imm_len(start_desc);
          modrm_d  = ofd_pkg::BYTE_RST;
          cnt_d    = 2'h0;
          if (start_desc.form == ofd_pkg::FORM_MODRM || start_desc.form == ofd_pkg::FORM_MODRM_IMM)
            state_d = ST_MODRM;
          else if (ofd_pkg::imm_len(start_desc) != ofd_pkg::LEN_NONE)
            state_d = ST_IMM;
          else
            state_d = ST_FINISH;
        end
      end
      ST_MODRM: begin
        if (take) begin
          modrm_d  = byte_data;
          next_len = ofd_pkg::disp_len(byte_data[7:6], byte_data[2:0]);
          disp_n_d = next_len;
          if (next_len != ofd_pkg::LEN_NONE)
            state_d = ST_DISP;
          else if (imm_n_q != ofd_pkg::LEN_NONE)
            state_d = ST_IMM;
          else
            state_d = ST_FINISH;
        end
      end
      ST_DISP: begin
        if (take) begin
          disp_d[{cnt_q[0], 3'b000} +: 8] = byte_data;
          if ({1'b0, cnt_q} == disp_n_q - 3'h1) begin
            cnt_d   = 2'h0;
            state_d = (imm_n_q != ofd_pkg::LEN_NONE) ? ST_IMM : ST_FINISH;
          end else begin
            cnt_d = cnt_q + 2'h1;
          end
        end
      end
      ST_IMM: begin
        if (take) begin
          // byte k lands at bits 8k: low before high, offset before segment
          imm_d[{cnt_q, 3'b000} +: 8] = byte_data;
          if ({1'b0, cnt_q} == imm_n_q - 3'h1) begin
            cnt_d   = 2'h0;
            state_d = ST_FINISH;
          end else begin
            cnt_d = cnt_q + 2'h1;
          end
        end
      end
      ST_FINISH: begin
        done_d         = 1'b1;
        state_d        = ST_IDLE;
        res_d.form     = desc_q.form;
        res_d.word     = desc_q.w;
        res_d.reg_dst  = ofd_pkg::gpr_sel(desc_q.w, modrm_q[5:3]);
        res_d.reg_src  = ofd_pkg::gpr_sel(desc_q.w, mf);
        res_d.mem_op   = (md != ofd_pkg::MOD_REGISTER);
        res_d.ea       = base + disp16;
        res_d.ea_dst   = ofd_pkg::WORD_RST;
        res_d.data_seg = desc_q.ovr_en ? desc_q.ovr : ofd_pkg::SEG_DATA_ZERO;
        res_d.dst_seg  = ofd_pkg::SEG_DATA_ONE;
        res_d.sreg_sel = ofd_pkg::ofd_seg_e'(desc_q.sreg);
        // single byte: signed only when s asks for it on a word op
        if (imm_n_q == ofd_pkg::LEN_ONE)
          res_d.imm = (desc_q.w && desc_q.s) ? ofd_pkg::sext8(imm_q[7:0])
                                             : {8'h00, imm_q[7:0]};
        else
          res_d.imm = imm_q[15:0];
        res_d.target_pc = regs_in.pc_end;
        res_d.target_ps = ofd_pkg::WORD_RST;
        case (desc_q.form)
          ofd_pkg::FORM_ACC_IMM: begin
            res_d.mem_op  = 1'b0;
            res_d.reg_dst = ofd_pkg::gpr_sel(desc_q.w, 3'b000);
          end
          ofd_pkg::FORM_SHORT: begin
            res_d.mem_op    = 1'b0;
            res_d.target_pc = regs_in.pc_end + ofd_pkg::sext8(imm_q[7:0]);
          end
          ofd_pkg::FORM_NEAR: begin
            res_d.mem_op    = 1'b0;
            res_d.target_pc = regs_in.pc_end + imm_q[15:0];
          end
          ofd_pkg::FORM_FAR: begin
            res_d.mem_op    = 1'b0;
            res_d.target_pc = imm_q[15:0];
            res_d.target_ps = imm_q[31:16];
          end
          ofd_pkg::FORM_RETN: res_d.mem_op = 1'b0;
          ofd_pkg::FORM_XLAT: begin
            res_d.mem_op = 1'b1;
            res_d.word   = 1'b0;
            res_d.ea     = regs_in.base_word + {8'h00, regs_in.acc_low};
          end
          ofd_pkg::FORM_BLOCK: begin
            res_d.mem_op = 1'b1;
            res_d.ea     = regs_in.src_index;
            res_d.ea_dst = regs_in.dst_index;
            // prefix may move the source only, never the destination
            res_d.dst_seg = ofd_pkg::SEG_DATA_ONE;
          end
          default: ;
        endcase
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // undefined flags hold their old value so nothing random leaks out
  always_comb begin
    case (flag_act)
      ofd_pkg::FLAG_CLEAR:   flag_new_d = 1'b0;
      ofd_pkg::FLAG_SET:     flag_new_d = 1'b1;
      ofd_pkg::FLAG_RESULT:  flag_new_d = flag_res;
      ofd_pkg::FLAG_RESTORE: flag_new_d = flag_saved;
      default:               flag_new_d = flag_old;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q     <= ST_IDLE;
      desc_q      <= '0;
      modrm_q     <= ofd_pkg::BYTE_RST;
      disp_q      <= ofd_pkg::WORD_RST;
      disp_n_q    <= ofd_pkg::LEN_NONE;
      imm_q       <= ofd_pkg::IMM_RST;
      imm_n_q     <= ofd_pkg::LEN_NONE;
      cnt_q       <= 2'h0;
      done_q      <= 1'b0;
      res_q       <= '0;
      idle_q      <= 1'b1;
      want_byte_q <= 1'b0;
      flag_new_q  <= 1'b0;
    end else begin
      state_q     <= state_d;
      desc_q      <= desc_d;
      modrm_q     <= modrm_d;
      disp_q      <= disp_d;
      disp_n_q    <= disp_n_d;
      imm_q       <= imm_d;
      imm_n_q     <= imm_n_d;
      cnt_q       <= cnt_d;
      done_q      <= done_d;
      res_q       <= res_d;
      idle_q      <= (state_d == ST_IDLE);
      want_byte_q <= (state_d == ST_MODRM || state_d == ST_DISP || state_d == ST_IMM);
      flag_new_q  <= flag_new_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_width_follows_bit: assert property (done_q && res_q.form != ofd_pkg::FORM_XLAT
    |-> res_q.word == desc_q.w) else $error("operand width differs from width bit");
  a_reg_field_map: assert property (done_q && res_q.form == ofd_pkg::FORM_MODRM
    |-> res_q.reg_src == {desc_q.w, modrm_q[2:0]}) else $error("source register misdecoded");
  a_disp_byte_count: assert property (
    (state_q == ST_MODRM && take && byte_data[7:6] == 2'b01)
    |=> disp_n_q == 3'h1 && state_q == ST_DISP) else $error("mode 01 wants one byte");
  a_disp_word_count: assert property (
    (state_q == ST_MODRM && take && byte_data[7:6] == 2'b10)
    |=> disp_n_q == 3'h2) else $error("mode 10 wants two bytes");
  a_direct_address: assert property (done_q && res_q.mem_op && md == 2'b00
    && mf == 3'b110 && res_q.form == ofd_pkg::FORM_MODRM |-> res_q.ea == disp_q)
    else $error("bad direct");
  a_imm_sign_ext: assert property (done_q && res_q.form == ofd_pkg::FORM_MODRM_IMM
    && desc_q.w && desc_q.s |-> res_q.imm[15:8] == {8{res_q.imm[7]}})
    else $error("imm not extended");
  a_imm_low_first: assert property ((state_q == ST_IMM && take && cnt_q == 2'h0) ##1
    (state_q == ST_IMM && take) |=> imm_q[15:8] == $past(byte_data))
    else $error("second immediate byte not high");
  a_seg_field_map: assert property (done_q && desc_q.sreg != 2'b11
    |-> res_q.sreg_sel == desc_q.sreg) else $error("segment field misdecoded");
  a_seg_eleven: assert property (done_q && desc_q.sreg == 2'b11
    |-> res_q.sreg_sel == ofd_pkg::SEG_DATA_ZERO) else $error("field 11 misdecoded");
  a_short_target: assert property (done_q && res_q.form == ofd_pkg::FORM_SHORT
    |-> res_q.target_pc == $past(regs_in.pc_end) + {{8{imm_q[7]}}, imm_q[7:0]})
    else $error("short target wrong");
  a_near_target: assert property (done_q && res_q.form == ofd_pkg::FORM_NEAR
    |-> res_q.target_pc == $past(regs_in.pc_end) + imm_q[15:0])
    else $error("near target wrong");
  // third far byte is the segment low byte, after both offset bytes
  a_far_seg_order: assert property (
    state_q == ST_IMM && take && cnt_q == 2'h2 && desc_q.form == ofd_pkg::FORM_FAR
    |=> imm_q[23:16] == $past(byte_data)) else $error("segment low byte misplaced");
  a_acc_implicit: assert property (done_q && res_q.form == ofd_pkg::FORM_ACC_IMM
    |-> res_q.reg_dst == {desc_q.w, 3'b000} && !res_q.mem_op)
    else $error("accumulator form misdecoded");
  a_xlat_index: assert property (done_q && res_q.form == ofd_pkg::FORM_XLAT
    |-> res_q.ea == $past(regs_in.base_word) + {8'h00, $past(regs_in.acc_low)})
    else $error("translate address wrong");
  a_block_index: assert property (done_q && res_q.form == ofd_pkg::FORM_BLOCK
    |-> res_q.ea == $past(regs_in.src_index) && res_q.ea_dst == $past(regs_in.dst_index))
    else $error("block index wrong");
  a_flag_fixed: assert property (
    flag_act == ofd_pkg::FLAG_CLEAR || flag_act == ofd_pkg::FLAG_SET
    |=> flag_new_q == ($past(flag_act) == ofd_pkg::FLAG_SET)) else $error("flag not forced");
  a_block_dst_seg: assert property (done_q && res_q.form == ofd_pkg::FORM_BLOCK
    |-> res_q.dst_seg == ofd_pkg::SEG_DATA_ONE
    && res_q.data_seg == (desc_q.ovr_en ? desc_q.ovr : ofd_pkg::SEG_DATA_ZERO))
    else $error("block segment misrouted");

  c_mem_disp16: cover property (state_q == ST_DISP && take && cnt_q == 2'h1);
  c_far_done: cover property (done_q && res_q.form == ofd_pkg::FORM_FAR);
  c_block_ovr: cover property (done_q && res_q.form == ofd_pkg::FORM_BLOCK && desc_q.ovr_en);
  c_direct_done: cover property (done_q && res_q.form == ofd_pkg::FORM_MODRM && md == 2'b00
    && mf == 3'b110);
  c_slow_imm: cover property (state_q == ST_IMM && want_byte_q && !byte_valid);

endmodule

// ### ofd_fetch_model.sv
`timescale 1ns/100ps
module ofd_fetch_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // byte handshake with the decoder
  input  wire logic       want_byte_q,
  input  wire logic       slow,
  output logic            byte_valid,
  output logic [7:0]      byte_data
);
  logic [7:0] q[$];
  int         pops    = 0;
  int         seen    = 0;
  logic       valid_r = 1'b0;
  logic [7:0] data_r  = 8'hA5;

  // each variable but the queue has one writer: pops on the rising edge, the rest on the falling one
  assign byte_valid = valid_r;
  assign byte_data  = data_r;

  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask

  // a byte leaves the queue only on the edge that accepts it
  always @(posedge clk) begin
    if (valid_r && want_byte_q && !sys_rst) begin
      void'(q.pop_front());
      pops++;
    end
  end

  // an offered byte is held until taken; idle data toggles so nothing stale reads as valid
  always @(negedge clk) begin
    if (!valid_r || pops != seen) begin
      if (q.size() > 0 && !(slow && $urandom_range(1, 0))) begin
        valid_r = 1'b1;
        data_r  = q[0];
      end else begin
        valid_r = 1'b0;
        data_r  = ~data_r;
      end
    end
    seen = pops;
  end
endmodule

// ### operand_field_decoder_tb.sv
`timescale 1ns/100ps
module operand_field_decoder_tb;
  logic               clk;
  logic               sys_rst;
  logic               start;
  logic               byte_valid;
  logic               flag_old;
  logic               flag_res;
  logic               flag_saved;
  logic               flag_new_q;
  logic               slow;
  logic               idle_q;
  logic               want_byte_q;
  logic               done_q;
  logic [7:0]         byte_data;
  ofd_pkg::ofd_desc_s start_desc;
  ofd_pkg::ofd_regs_s regs_in;
  ofd_pkg::ofd_flag_e flag_act;
  ofd_pkg::ofd_res_s  res_q;
  ofd_pkg::ofd_form_e f;
  int                 fail_count;
  int                 cmp_count;
  int                 k;
  logic [7:0]         bq[$];
  logic [1:0]         md;
  logic [1:0]         dsx;
  logic [2:0]         rg;
  logic [2:0]         mm;
  logic               w;
  logic               s;
  logic               fx;
  logic [15:0]        d;
  logic [15:0]        im;
  logic [95:0]        rnd;

  ofd_decoder ofd_decoder_inst (
    .clk(clk), .sys_rst(sys_rst), .start(start), .start_desc(start_desc),
    .byte_valid(byte_valid), .byte_data(byte_data), .regs_in(regs_in),
    .flag_act(flag_act), .flag_old(flag_old), .flag_res(flag_res), .flag_saved(flag_saved),
    .idle_q(idle_q), .want_byte_q(want_byte_q), .done_q(done_q), .res_q(res_q),
    .flag_new_q(flag_new_q)
  );

  ofd_fetch_model ofd_fetch_model_inst (
    .clk(clk), .sys_rst(sys_rst), .want_byte_q(want_byte_q), .slow(slow),
    .byte_valid(byte_valid), .byte_data(byte_data)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic logic [15:0] ea_exp(input logic [1:0] m, input logic [2:0] b);
    logic [15:0] x;
    case (b)
      3'h0: x = regs_in.base_word + regs_in.src_index;
      3'h1: x = regs_in.base_word + regs_in.dst_index;
      3'h2: x = regs_in.frame_base + regs_in.src_index;
      3'h3: x = regs_in.frame_base + regs_in.dst_index;
      3'h4: x = regs_in.src_index;
      3'h5: x = regs_in.dst_index;
      3'h6: x = regs_in.frame_base;
      default: x = regs_in.base_word;
    endcase
    if (m == 2'h0) return (b == 3'h6) ? d : x;
    if (m == 2'h1) return x + {{8{d[7]}}, d[7:0]};
    return x + d;
  endfunction

  // one instruction: bytes queued at the far side, start held one edge, done awaited
  task automatic run(input ofd_pkg::ofd_form_e fm, input logic wb, input logic sb,
                     input logic [1:0] sg);
    int n;
    rnd = {$urandom(), $urandom(), $urandom()};
    regs_in = rnd[87:0];
    slow = 1'($urandom_range(1, 0));
    start_desc = '{form: fm, w: wb, s: sb, sreg: sg, ovr_en: 1'($urandom_range(1, 0)),
                   ovr: ofd_pkg::ofd_seg_e'(2'($urandom))};
    dsx = start_desc.ovr_en ? start_desc.ovr : ofd_pkg::SEG_DATA_ZERO;
    foreach (bq[j]) ofd_fetch_model_inst.push(bq[j]);
    bq.delete();
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    n = 0;
    while (done_q !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (done_q !== 1'b1) begin
      fail_count++;
      $display("ERROR done_q expected 1 seen timeout");
      complete_run();
    end
  endtask

  initial begin
    void'($urandom(91931));
    sys_rst = 1'b1;
    start = 1'b0;
    start_desc = '0;
    regs_in = '0;
    flag_act = ofd_pkg::FLAG_KEEP;
    flag_old = 1'b0;
    flag_res = 1'b0;
    flag_saved = 1'b0;
    slow = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk("idle_rst", idle_q, 1'b1);
    chk("want_rst", want_byte_q, 1'b0);
    chk("done_rst", done_q, 1'b0);
    chk("res_rst", res_q == '0, 1'b1);
    sys_rst = 1'b0;
    for (int i = 0; i < 24; i++) begin
      flag_act = ofd_pkg::ofd_flag_e'(3'(i % 6));
      {flag_old, flag_res, flag_saved} = 3'($urandom);
      @(negedge clk);
      case (flag_act)
        ofd_pkg::FLAG_CLEAR:   fx = 1'b0;
        ofd_pkg::FLAG_SET:     fx = 1'b1;
        ofd_pkg::FLAG_RESULT:  fx = flag_res;
        ofd_pkg::FLAG_RESTORE: fx = flag_saved;
        default:               fx = flag_old;
      endcase
      chk("flag", flag_new_q, fx);
    end
    for (int i = 0; i < 64; i++) begin
      md = i < 6 ? 2'h0 : 2'($urandom);
      rg = 3'($urandom);
      mm = i < 6 ? 3'h6 : 3'($urandom);
      {w, s} = 2'($urandom);
      d = 16'($urandom);
      im = 16'($urandom);
      f = i[0] ? ofd_pkg::FORM_MODRM_IMM : ofd_pkg::FORM_MODRM;
      bq = {{md, rg, mm}};
      if (md == 2'h1) bq.push_back(d[7:0]);
      if (md == 2'h2 || (md == 2'h0 && mm == 3'h6)) bq = {bq, d[7:0], d[15:8]};
      if (f == ofd_pkg::FORM_MODRM_IMM) bq.push_back(im[7:0]);
      if (f == ofd_pkg::FORM_MODRM_IMM && w && !s) bq.push_back(im[15:8]);
      run(f, w, s, i[3:2]);
      chk("word", res_q.word, w);
      chk("mem_op", res_q.mem_op, md != 2'h3);
      chk("sreg_sel", res_q.sreg_sel, i[3:2]);
      if (!i[0]) chk("reg_dst", res_q.reg_dst, {w, rg});
      if (md == 2'h3) chk("reg_src", res_q.reg_src, {w, mm});
      else chk("ea", res_q.ea, ea_exp(md, mm));
      if (md != 2'h3) chk("data_seg", res_q.data_seg, dsx);
      if (i[0] && w) chk("imm", res_q.imm, s ? {{8{im[7]}}, im[7:0]} : im);
    end
    for (int i = 0; i < 42; i++) begin
      {w, s} = 2'($urandom);
      d = 16'($urandom);
      im = 16'($urandom);
      if (i < 7) d = 16'h0080;
      else if (i < 14) d = 16'hFF7F;
      else if (i < 21) d = 16'hFFFF;
      k = i % 7;
      f = ofd_pkg::ofd_form_e'(k == 6 ? 4'h2 : 4'(k + 3));
      case (k)
        0: bq = {d[7:0]};
        1, 3: bq = {d[7:0], d[15:8]};
        2: bq = {d[7:0], d[15:8], im[7:0], im[15:8]};
        6: bq = (w && !s) ? {im[7:0], im[15:8]} : {im[7:0]};
        default: bq.delete();
      endcase
      run(f, w, s, 2'h0);
      case (k)
        0: chk("short", res_q.target_pc, regs_in.pc_end + {{8{d[7]}}, d[7:0]});
        1: chk("near", res_q.target_pc, regs_in.pc_end + d);
        2: begin
          chk("far_pc", res_q.target_pc, d);
          chk("far_ps", res_q.target_ps, im);
        end
        3: chk("count", res_q.imm, d);
        4: begin
          chk("xlat", res_q.ea, regs_in.base_word + {8'h00, regs_in.acc_low});
          chk("xlat_w", res_q.word, 1'b0);
        end
        5: begin
          chk("blk_src", res_q.ea, regs_in.src_index);
          chk("blk_dst", res_q.ea_dst, regs_in.dst_index);
          chk("blk_dseg", res_q.dst_seg, ofd_pkg::SEG_DATA_ONE);
          chk("blk_sseg", res_q.data_seg, dsx);
        end
        default: begin
          chk("acc", res_q.reg_dst, {w, 3'h0});
          if (w) chk("acc_imm", res_q.imm, s ? {{8{im[7]}}, im[7:0]} : im);
        end
      endcase
    end
    complete_run();
  end
endmodule
